// ### usr_baud_tick.sv
// Bit-sample strobe generator counting edges of the receive bit clock.
`timescale 1ns/100ps
module usr_baud_tick #(
  parameter int W = 7
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Edge strobe, restart and division values.
  input wire logic edge_in,
  input wire logic restart,
  input wire logic [W-1:0] full,
  input wire logic [W-1:0] half,
  // Sample strobe.
  output logic tick
);
  logic [W-1:0] cnt;

  // A restart lands the first strobe mid-bit, later ones a whole bit apart.
  assign tick = edge_in && !restart && (cnt <= W'(1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= W'(1);
    end else if (restart) begin
      cnt <= half;
    end else if (edge_in) begin
      cnt <= (cnt <= W'(1)) ? full : cnt - W'(1);
    end
  end
endmodule // usr_baud_tick

// ### usr_far_end.sv
// Behavioural far-end model: serial sender, receive bit clock and modem inputs.
`timescale 1ns/100ps
module usr_far_end (
  // Clock.
  input wire logic pclk,
  // Serial line, bit clock and shared pin.
  output logic rx_serial,
  output logic rx_bit_clock,
  output logic sync_or_break_in,
  // Modem inputs of the block.
  output logic dsr_n,
  output logic cts_n
);
  int half = 16;
  initial begin
    rx_serial = 1'b1;
    rx_bit_clock = 1'b0;
    sync_or_break_in = 1'b0;
    dsr_n = 1'b1;
    cts_n = 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////////
  // The bit clock runs only inside frames and rests low between them.
  task automatic pulse(input int n);
    repeat (n) begin
      repeat (half) @(posedge pclk);
      rx_bit_clock <= 1'b1;
      repeat (half) @(posedge pclk);
      rx_bit_clock <= 1'b0;
    end
  endtask
  task automatic level(input logic v);
    @(posedge pclk);
    rx_serial <= v;
  endtask
  task automatic modem(input logic dsr, input logic cts);
    @(posedge pclk);
    dsr_n <= dsr;
    cts_n <= cts;
  endtask
  task automatic ext_pin(input logic v);
    @(posedge pclk);
    sync_or_break_in <= v;
  endtask
  // The start bit lasts one bit time; the receiver checks it at mid-bit.
  task automatic send_async(input int f, input logic [7:0] ch);
    rx_serial <= 1'b0;
    pulse(f);
    for (int i = 0; i < 8; i++) begin
      rx_serial <= ch[i];
      pulse(f);
    end
    rx_serial <= 1'b1;
    pulse(f);
  endtask
  task automatic send_sync(input logic [7:0] ch);
    for (int i = 0; i < 8; i++) begin
      rx_serial <= ch[i];
      pulse(1);
    end
  endtask
endmodule // usr_far_end

// ### usr_pkg.sv
// Shared constants and types of the receive, status and modem-pin block.
package usr_pkg;
  localparam logic [7:0] ADDR_DATA = 8'h00;
  localparam logic [7:0] ADDR_MODE = 8'h04;
  localparam logic [7:0] ADDR_CMD = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0C;
  localparam logic [7:0] ADDR_SYNC = 8'h10;
  localparam logic [7:0] ADDR_IRQ_ST = 8'h14;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;
  localparam logic [1:0] BAUD_SYNC = 2'h0;
  localparam logic [1:0] BAUD_X1 = 2'h1;
  localparam logic [1:0] BAUD_X16 = 2'h2;
  localparam logic [1:0] BAUD_X64 = 2'h3;
  localparam int MODE_EXT = 6;
  localparam int CMD_TXEN = 0;
  localparam int CMD_DTR = 1;
  localparam int CMD_RXEN = 2;
  localparam int CMD_ERR_RST = 4;
  localparam int CMD_RTS = 5;
  localparam int CMD_HUNT = 7;
  localparam int STAT_RX_CHAR_READY = 1;
  localparam int STAT_OVR = 4;
  localparam int STAT_SYNBRK = 6;
  localparam int STAT_DSR = 7;
  localparam int IRQ_RX = 0;
  localparam int IRQ_OVR = 1;
  localparam int IRQ_SYNBRK = 2;
  localparam int IRQ_W = 3;
  localparam int DIV_W = 7;
  localparam logic [6:0] DIV_ONE = 7'h01;
  localparam logic [6:0] DIV_16 = 7'h10;
  localparam logic [6:0] DIV_16_HALF = 7'h08;
  localparam logic [6:0] DIV_64 = 7'h40;
  localparam logic [6:0] DIV_64_HALF = 7'h20;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] CMD_RST = 8'h00;
  localparam logic [7:0] SYNC_RST = 8'h00;
  localparam logic [1:0] BREAK_STOPS = 2'h2;
  typedef enum logic [4:0] {
    RX_IDLE = 5'b00001,
    RX_START = 5'b00010,
    RX_DATA = 5'b00100,
    RX_STOP = 5'b01000,
    RX_HUNT = 5'b10000
  } usr_rx_state_t;
endpackage

// ### usr_rx_top.sv
// Receiver, status flags, shared sync/break pin and modem lines behind APB.
// Overview of operation
// - Receive-ready stays high while a complete character waits to be read.
// - A data read clears receive-ready at the start of the read access.
// - A character finishing before the previous was read replaces it and sets overrun.
// - In synchronous mode one bit is taken per receive bit-clock cycle.
// - In asynchronous mode the bit rate is the bit clock divided by 1, 16 or 64.
// - Internal sync mode drives the shared pin high once the sync character matches.
// - Internal sync mode returns the shared pin low when status is read.
// - External sync mode takes the shared pin as input and starts assembly when it is high.
// - Asynchronous mode drives break high when two consecutive stop bits are low.
// - Break is cleared once the receive line is high again.
// - Break reads low during and after reset.
// - Status shows the current data-set-ready level.
// - Terminal-ready and request-to-send follow the command bits until changed.
// - With transmit enabled, sending is allowed only while clear-to-send is low.
//
// Local design decisions: the APB register port and the address map.
`timescale 1ns/100ps
module usr_rx_top #(
  parameter int CHAR_BITS = 8
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial receive side.
  input wire logic rx_serial,
  input wire logic rx_bit_clock,
  input wire logic sync_or_break_in,
  output logic sync_or_break_out,
  output logic sync_or_break_oe,
  // Modem lines.
  input wire logic dsr_n,
  input wire logic cts_n,
  output logic dtr_n,
  output logic rts_n,
  output logic tx_send_ok,
  // Interrupt.
  output logic irq
);
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] mode;
  logic [7:0] cmd;
  logic [7:0] sync_char;
  logic [7:0] rx_data;
  logic rx_ready;
  logic overrun;
  logic sync_det;
  logic break_det;
  logic [1:0] stop_low_cnt;
  logic [usr_pkg::IRQ_W-1:0] irq_st;
  logic [usr_pkg::IRQ_W-1:0] irq_mask;
  logic rxc_q;
  logic [3:0] bit_cnt;
  usr_pkg::usr_rx_state_t state;
  logic [usr_pkg::DIV_W-1:0] div_full;
  logic [usr_pkg::DIV_W-1:0] div_half;
  logic [CHAR_BITS-1:0] shreg;
  logic tick;

  wire setup = psel && !penable;
  wire wr_fire = psel && penable && pready && pwrite;
  wire rd_data = setup && !pwrite && (paddr == usr_pkg::ADDR_DATA);
  wire rd_stat = setup && !pwrite && (paddr == usr_pkg::ADDR_STAT);
  wire wr_mode = wr_fire && (paddr == usr_pkg::ADDR_MODE);
  wire wr_cmd = wr_fire && (paddr == usr_pkg::ADDR_CMD);
  wire sync_mode = (mode[1:0] == usr_pkg::BAUD_SYNC);
  wire ext_sync = sync_mode && mode[usr_pkg::MODE_EXT];
  wire rx_en = cmd[usr_pkg::CMD_RXEN];
  wire rise = rx_bit_clock && !rxc_q;
  wire last_bit = (bit_cnt == 4'(CHAR_BITS - 1));
  wire restart = (state == usr_pkg::RX_IDLE) && !sync_mode && rx_en && !rx_serial;
  // Sync mode reloads the divider in idle, so a count left by a slower factor cannot delay bit one.
  wire tick_restart = restart || ((state == usr_pkg::RX_IDLE) && sync_mode);
  wire [CHAR_BITS-1:0] next_shreg = {rx_serial, shreg[CHAR_BITS-1:1]};
  wire sync_hit = (state == usr_pkg::RX_HUNT) && !ext_sync && tick
    && (next_shreg == sync_char);
  wire ext_go = (state == usr_pkg::RX_HUNT) && ext_sync && sync_or_break_in;
  wire load = tick && (sync_mode ? (state == usr_pkg::RX_DATA) && last_bit
    : (state == usr_pkg::RX_STOP));
  wire stop_low = tick && !sync_mode && (state == usr_pkg::RX_STOP) && !rx_serial;
  wire break_set = stop_low && (stop_low_cnt == usr_pkg::BREAK_STOPS - 2'h1);
  wire mapped = (paddr == usr_pkg::ADDR_DATA) || (paddr == usr_pkg::ADDR_MODE)
    || (paddr == usr_pkg::ADDR_CMD) || (paddr == usr_pkg::ADDR_STAT)
    || (paddr == usr_pkg::ADDR_SYNC) || (paddr == usr_pkg::ADDR_IRQ_ST)
    || (paddr == usr_pkg::ADDR_IRQ_MASK);
  wire [usr_pkg::IRQ_W-1:0] irq_ev = {sync_hit || break_set, load && rx_ready, load};

  ////////////////////////////////////////////////////////////////////////////
  // Bit-clock edge, divider and shifter.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxc_q <= 1'b0;
    end else begin
      rxc_q <= rx_bit_clock;
    end
  end

  always_comb begin
    case (mode[1:0])
      usr_pkg::BAUD_X16: begin
        div_full = usr_pkg::DIV_16;
        div_half = usr_pkg::DIV_16_HALF;
      end
      usr_pkg::BAUD_X64: begin
        div_full = usr_pkg::DIV_64;
        div_half = usr_pkg::DIV_64_HALF;
      end
      default: begin
        div_full = usr_pkg::DIV_ONE;
        div_half = usr_pkg::DIV_ONE;
      end
    endcase
  end

  usr_baud_tick #(.W(usr_pkg::DIV_W)) u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .edge_in(rise),
    .restart(tick_restart),
    .full(div_full),
    .half(div_half),
    .tick(tick)
  );

  usr_shifter #(.W(CHAR_BITS)) u_shift (
    .pclk(pclk),
    .presetn(presetn),
    .shift_en(tick && ((state == usr_pkg::RX_DATA) || (state == usr_pkg::RX_HUNT))),
    .bit_in(rx_serial),
    .data(shreg)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Receive sequencer.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= usr_pkg::RX_IDLE;
      bit_cnt <= 4'h0;
    end else if (wr_mode || !rx_en) begin
      state <= usr_pkg::RX_IDLE;
      bit_cnt <= 4'h0;
    end else if (wr_cmd && sync_mode && pwdata[usr_pkg::CMD_HUNT]) begin
      state <= usr_pkg::RX_HUNT;
      bit_cnt <= 4'h0;
    end else begin
      case (state)
        usr_pkg::RX_IDLE: begin
          if (restart) begin
            state <= usr_pkg::RX_START;
          end else if (sync_mode) begin
            state <= usr_pkg::RX_HUNT;
          end
        end
        usr_pkg::RX_START: begin
          if (tick) begin
            state <= rx_serial ? usr_pkg::RX_IDLE : usr_pkg::RX_DATA;
            bit_cnt <= 4'h0;
          end
        end
        usr_pkg::RX_DATA: begin
          if (tick) begin
            bit_cnt <= last_bit ? 4'h0 : bit_cnt + 4'h1;
            if (last_bit && !sync_mode) begin
              state <= usr_pkg::RX_STOP;
            end
          end
        end
        usr_pkg::RX_STOP: begin
          if (tick) begin
            state <= usr_pkg::RX_IDLE;
          end
        end
        usr_pkg::RX_HUNT: begin
          if (sync_hit || ext_go) begin
            state <= usr_pkg::RX_DATA;
            bit_cnt <= 4'h0;
          end
        end
        default: begin
          state <= usr_pkg::RX_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Received character and its flags; a setting event wins over a clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_data <= 8'h00;
      rx_ready <= 1'b0;
    end else if (load) begin
      // In sync mode the last bit is still being shifted in on this cycle.
      rx_data <= 8'(sync_mode ? next_shreg : shreg);
      rx_ready <= 1'b1;
    end else if (rd_data) begin
      rx_ready <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overrun <= 1'b0;
    end else if (load && rx_ready && !rd_data) begin
      overrun <= 1'b1;
    end else if (wr_cmd && pwdata[usr_pkg::CMD_ERR_RST]) begin
      overrun <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_det <= 1'b0;
    end else if (sync_hit) begin
      sync_det <= 1'b1;
    end else if (rd_stat || !sync_mode) begin
      sync_det <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stop_low_cnt <= 2'h0;
      break_det <= 1'b0;
    end else begin
      if (rx_serial) begin
        stop_low_cnt <= 2'h0;
      end else if (stop_low && stop_low_cnt != usr_pkg::BREAK_STOPS) begin
        stop_low_cnt <= stop_low_cnt + 2'h1;
      end
      if (break_set) begin
        break_det <= 1'b1;
      end else if (rx_serial || sync_mode) begin
        break_det <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_or_break_out <= 1'b0;
      sync_or_break_oe <= 1'b1;
      dtr_n <= 1'b1;
      rts_n <= 1'b1;
      tx_send_ok <= 1'b0;
    end else begin
      sync_or_break_out <= sync_mode ? sync_det : break_det;
      sync_or_break_oe <= !ext_sync;
      dtr_n <= !cmd[usr_pkg::CMD_DTR];
      rts_n <= !cmd[usr_pkg::CMD_RTS];
      tx_send_ok <= cmd[usr_pkg::CMD_TXEN] && !cts_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers and APB.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode <= usr_pkg::MODE_RST;
      cmd <= usr_pkg::CMD_RST;
      sync_char <= usr_pkg::SYNC_RST;
      irq_mask <= '0;
    end else if (wr_fire) begin
      case (paddr)
        usr_pkg::ADDR_MODE: mode <= pwdata[7:0];
        usr_pkg::ADDR_CMD: cmd <= pwdata[7:0];
        usr_pkg::ADDR_SYNC: sync_char <= pwdata[7:0];
        usr_pkg::ADDR_IRQ_MASK: irq_mask <= pwdata[usr_pkg::IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_st <= '0;
      irq <= 1'b0;
    end else begin
      if (wr_fire && paddr == usr_pkg::ADDR_IRQ_ST) begin
        irq_st <= (irq_st & ~pwdata[usr_pkg::IRQ_W-1:0]) | irq_ev;
      end else begin
        irq_st <= irq_st | irq_ev;
      end
      irq <= |(irq_st & irq_mask);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      pslverr <= setup && !mapped;
      if (setup && !pwrite) begin
        case (paddr)
          usr_pkg::ADDR_DATA: prdata <= {24'h00_0000, rx_data};
          usr_pkg::ADDR_MODE: prdata <= {24'h00_0000, mode};
          usr_pkg::ADDR_CMD: prdata <= {24'h00_0000, cmd};
          usr_pkg::ADDR_STAT: begin
            prdata <= 32'h0000_0000;
            prdata[usr_pkg::STAT_RX_CHAR_READY] <= rx_ready;
            prdata[usr_pkg::STAT_OVR] <= overrun;
            prdata[usr_pkg::STAT_SYNBRK] <= sync_mode ? sync_det : break_det;
            prdata[usr_pkg::STAT_DSR] <= !dsr_n;
          end
          usr_pkg::ADDR_SYNC: prdata <= {24'h00_0000, sync_char};
          usr_pkg::ADDR_IRQ_ST: prdata <= {29'h0, irq_st};
          usr_pkg::ADDR_IRQ_MASK: prdata <= {29'h0, irq_mask};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic [6:0] rise_cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rise_cnt <= 7'h00;
    end else if (tick || restart) begin
      rise_cnt <= 7'h00;
    end else if (rise) begin
      rise_cnt <= rise_cnt + 7'h01;
    end
  end

  a_ready_set: assert property (load |=> rx_ready) else $error("ready not set");
  a_ready_clear: assert property (rd_data && !load |=> !rx_ready)
    else $error("ready not cleared");
  a_overrun_set: assert property (load && rx_ready && !rd_data |=> overrun && rx_ready)
    else $error("overrun missed");
  a_sync_rate: assert property (sync_mode && rise && state == usr_pkg::RX_DATA |-> tick)
    else $error("sync bit skipped");
  a_async_div: assert property (tick && !sync_mode && state == usr_pkg::RX_DATA
    && bit_cnt != 4'h0 |-> rise_cnt == div_full - 7'h01)
    else $error("async divide wrong");
  a_sync_pin: assert property (sync_hit |-> ##2 sync_or_break_out && sync_or_break_oe)
    else $error("sync pin not high");
  a_sync_read: assert property (rd_stat && !sync_hit && sync_mode |-> ##2 !sync_or_break_out)
    else $error("sync pin not cleared");
  a_ext_start: assert property (ext_go && !wr_mode && !wr_cmd && rx_en |=>
    state == usr_pkg::RX_DATA && !sync_or_break_oe) else $error("ext start missed");
  a_break_set: assert property (break_set |-> ##2 sync_or_break_out)
    else $error("break not shown");
  a_break_clear: assert property (break_det && rx_serial && !break_set |=> !break_det)
    else $error("break not cleared");
  a_dsr_status: assert property (rd_stat |=> prdata[usr_pkg::STAT_DSR] == !$past(dsr_n))
    else $error("dsr status wrong");
  a_modem_out: assert property (wr_cmd |-> ##2 dtr_n == !$past(pwdata[usr_pkg::CMD_DTR], 2)
    && rts_n == !$past(pwdata[usr_pkg::CMD_RTS], 2)) else $error("modem out wrong");
  a_cts_gate: assert property (cts_n |=> !tx_send_ok) else $error("send while cts high");

  c_char_rx: cover property (load && !sync_mode);
  c_overrun: cover property (load && rx_ready);
  c_sync_hunt: cover property (sync_hit);
  c_break: cover property (break_set);
endmodule // usr_rx_top

// ### usr_rx_top_tb.sv
// Self-checking testbench of the receive, status and modem-pin block.
`timescale 1ns/100ps
module usr_rx_top_tb;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic rx_serial;
  logic rx_bit_clock;
  logic sync_or_break_in;
  logic sync_or_break_out;
  logic sync_or_break_oe;
  logic dsr_n;
  logic cts_n;
  logic dtr_n;
  logic rts_n;
  logic tx_send_ok;
  logic irq;
  logic [31:0] rdata;
  logic rerr;
  int fails = 0;
  int n_tests = 0;
  usr_rx_top DUT (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .rx_serial(rx_serial),
    .rx_bit_clock(rx_bit_clock),
    .sync_or_break_in(sync_or_break_in),
    .sync_or_break_out(sync_or_break_out),
    .sync_or_break_oe(sync_or_break_oe),
    .dsr_n(dsr_n),
    .cts_n(cts_n),
    .dtr_n(dtr_n),
    .rts_n(rts_n),
    .tx_send_ok(tx_send_ok),
    .irq(irq)
  );
  usr_far_end far (
    .pclk(pclk),
    .rx_serial(rx_serial),
    .rx_bit_clock(rx_bit_clock),
    .sync_or_break_in(sync_or_break_in),
    .dsr_n(dsr_n),
    .cts_n(cts_n)
  );
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Each transfer is followed by six idle clocks of recovery.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      fails++;
      $display("ERROR at %0t: no ready from the slave", $time);
    end
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (6) @(posedge pclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdata, exp);
  endtask
  task automatic stat_bit(input int b, input logic e);
    apb(1'b0, usr_pkg::ADDR_STAT, 32'h0);
    chk(32'(rdata[b]), 32'(e));
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [7:0] regs [5];
    regs = '{usr_pkg::ADDR_MODE, usr_pkg::ADDR_CMD, usr_pkg::ADDR_SYNC,
      usr_pkg::ADDR_IRQ_ST, usr_pkg::ADDR_IRQ_MASK};
    foreach (regs[i]) rd(regs[i], 32'h0);
    rd(8'h1C, 32'h0);
    chk(32'(rerr), 32'h1);
    chk(32'(sync_or_break_out), 32'h0);
  endtask
  task automatic t_modem();
    apb(1'b1, usr_pkg::ADDR_CMD, 32'h22);
    chk(32'({dtr_n, rts_n}), 32'h0);
    apb(1'b1, usr_pkg::ADDR_CMD, 32'h02);
    chk(32'({dtr_n, rts_n}), 32'h1);
    apb(1'b1, usr_pkg::ADDR_CMD, 32'h20);
    chk(32'({dtr_n, rts_n}), 32'h2);
    apb(1'b1, usr_pkg::ADDR_CMD, 32'h01);
    chk(32'(tx_send_ok), 32'h0);
    far.modem(1'b0, 1'b1);
    stat_bit(usr_pkg::STAT_DSR, 1'b1);
    chk(32'(tx_send_ok), 32'h0);
    far.modem(1'b1, 1'b0);
    repeat (3) @(posedge pclk);
    chk(32'(tx_send_ok), 32'h1);
    stat_bit(usr_pkg::STAT_DSR, 1'b0);
    far.modem(1'b1, 1'b1);
    repeat (3) @(posedge pclk);
    chk(32'(tx_send_ok), 32'h0);
  endtask
  task automatic t_rates();
    logic [1:0] md [3];
    int fs [3];
    md = '{usr_pkg::BAUD_X1, usr_pkg::BAUD_X16, usr_pkg::BAUD_X64};
    fs = '{1, 16, 64};
    for (int k = 0; k < 3; k++) begin
      far.half = (k == 0) ? 16 : 4;
      apb(1'b1, usr_pkg::ADDR_MODE, 32'(md[k]));
      apb(1'b1, usr_pkg::ADDR_CMD, 32'h04);
      far.send_async(fs[k], 8'hA5 ^ 8'(k));
      stat_bit(usr_pkg::STAT_RX_CHAR_READY, 1'b1);
      rd(usr_pkg::ADDR_DATA, 32'(8'hA5 ^ 8'(k)));
      stat_bit(usr_pkg::STAT_RX_CHAR_READY, 1'b0);
    end
  endtask
  task automatic t_overrun();
    far.half = 16;
    apb(1'b1, usr_pkg::ADDR_MODE, 32'(usr_pkg::BAUD_X1));
    far.send_async(1, 8'h11);
    far.send_async(1, 8'h22);
    stat_bit(usr_pkg::STAT_OVR, 1'b1);
    rd(usr_pkg::ADDR_DATA, 32'h22);
    rd(usr_pkg::ADDR_IRQ_ST, 32'h3);
    chk(32'(irq), 32'h0);
    apb(1'b1, usr_pkg::ADDR_IRQ_MASK, 32'h2);
    chk(32'(irq), 32'h1);
    apb(1'b1, usr_pkg::ADDR_IRQ_ST, 32'h3);
    chk(32'(irq), 32'h0);
    apb(1'b1, usr_pkg::ADDR_CMD, 32'h14);
    stat_bit(usr_pkg::STAT_OVR, 1'b0);
  endtask
  task automatic t_break();
    apb(1'b1, usr_pkg::ADDR_IRQ_MASK, 32'h4);
    far.level(1'b0);
    far.pulse(24);
    chk(32'(sync_or_break_out), 32'h1);
    chk(32'(irq), 32'h1);
    far.level(1'b1);
    repeat (4) @(posedge pclk);
    chk(32'(sync_or_break_out), 32'h0);
    apb(1'b1, usr_pkg::ADDR_IRQ_ST, 32'h7);
    chk(32'(irq), 32'h0);
    stat_bit(usr_pkg::STAT_OVR, 1'b1);
    // A reset in mid-run must clear the flags left by the break characters.
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    chk(32'({sync_or_break_out, dtr_n, irq}), 32'h2);
    presetn <= 1'b1;
    rd(usr_pkg::ADDR_STAT, 32'h0);
  endtask
  task automatic t_sync();
    apb(1'b1, usr_pkg::ADDR_MODE, 32'(usr_pkg::BAUD_SYNC));
    apb(1'b1, usr_pkg::ADDR_SYNC, 32'h96);
    apb(1'b1, usr_pkg::ADDR_CMD, 32'h84);
    far.send_sync(8'h96);
    chk(32'({sync_or_break_out, sync_or_break_oe}), 32'h3);
    stat_bit(usr_pkg::STAT_SYNBRK, 1'b1);
    chk(32'(sync_or_break_out), 32'h0);
    far.send_sync(8'h3C);
    rd(usr_pkg::ADDR_DATA, 32'h3C);
  endtask
  task automatic t_ext();
    apb(1'b1, usr_pkg::ADDR_MODE, 32'h40);
    apb(1'b1, usr_pkg::ADDR_CMD, 32'h84);
    chk(32'(sync_or_break_oe), 32'h0);
    far.ext_pin(1'b1);
    repeat (4) @(posedge pclk);
    far.send_sync(8'h5A);
    rd(usr_pkg::ADDR_DATA, 32'h5A);
    far.ext_pin(1'b0);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #1500000;
    fails++;
    $display("ERROR at %0t: timeout", $time);
    report_and_stop();
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (10) @(posedge pclk);
    chk(32'({sync_or_break_out, dtr_n, irq}), 32'h2);
    presetn <= 1'b1;
    t_reset();
    t_modem();
    t_rates();
    t_overrun();
    t_break();
    t_sync();
    t_ext();
    report_and_stop();
  end
endmodule // usr_rx_top_tb

// ### usr_shifter.sv
// LSB-first serial-in shift register.
`timescale 1ns/100ps
module usr_shifter #(
  parameter int W = 8
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Serial input.
  input wire logic shift_en,
  input wire logic bit_in,
  // Parallel view.
  output logic [W-1:0] data
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data <= '0;
    end else if (shift_en) begin
      data <= {bit_in, data[W-1:1]};
    end
  end
endmodule // usr_shifter
